/* exception_priority_vectoring.sv */
// exception sequencer: ranking, stacking, mask setting and vectoring
`timescale 1ns/10ps
`default_nettype none
module exception_priority_vectoring
  import exc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wdt_overflow,
  input wire logic advanced_mode_cfg,
  input wire logic user_bit_enable,
  input wire logic instr_done,
  input wire logic int_req,
  input wire logic [VEC_W-1:0] int_vec,
  input wire logic trap_instr,
  input wire logic [1:0] trap_num,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [CCR_W-1:0] cond_code_reg,
  input wire logic stack_ack,
  input wire logic vec_ack,
  input wire logic [PC_W-1:0] vec_data,
  output logic cpu_halt,
  output logic periph_reset_n,
  output logic stack_push,
  output logic [PC_W-1:0] stack_data,
  output logic vec_read,
  output logic [ADDR_W-1:0] vec_addr,
  output logic ccr_set_i,
  output logic ccr_set_ui,
  output logic exec_start,
  output logic [PC_W-1:0] exec_pc,
  output logic int_ack,
  output logic int_blocked
);

  state_t state_q, state_d;
  kind_t kind_q, kind_d;
  logic rst_meta_q, rst_sync_q;
  logic adv_q;
  logic trap_pend_q;
  logic [1:0] trap_num_q;
  logic [VEC_W-1:0] vec_num_q, vec_num_d;
  logic block_q;
  logic int_ok;
  logic take_int, take_trap;

  // ==========================================================
  // reset release
  // two flops keep the release clean of the pin's timing
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  vec_addr_gen u_vec_addr (
    .clk(clk),
    .rst_n(rst_sync_q),
    .vec_num(vec_num_q),
    .advanced(adv_q),
    .addr_q(vec_addr)
  );

  // ==========================================================
  // acceptance
  // (RULE10) reserved vector numbers are never accepted
  assign int_ok = int_req && !block_q && !vec_reserved(int_vec) && (int_vec <= VEC_LAST);
  // (RULE4) only at an instruction or sequence boundary
  assign take_int = int_ok && (instr_done || (state_q == ST_JUMP));
  // (RULE2) trap pending or just executed
  assign take_trap = (trap_pend_q || trap_instr) && (instr_done || (state_q == ST_JUMP));

  // ==========================================================
  // sequencer
  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    vec_num_d = vec_num_q;
    case (state_q)
      ST_RESET:
      begin
        // (RULE3) begin at release, (RULE6) straight to mask
        state_d = ST_SET_MASK;
        kind_d = KIND_RESET;
        // (RULE7) reset vector
        vec_num_d = VEC_RESET;
      end
      ST_RUN, ST_JUMP:
      begin
        if (state_q == ST_JUMP)
          state_d = ST_RUN;
        // (RULE1) interrupt ranks above trap
        if (take_int)
        begin
          state_d = ST_PUSH_PC;
          kind_d = KIND_INT;
          // (RULE9) controller supplies nmi/irq/internal vector
          vec_num_d = int_vec;
        end
        else if (take_trap)
        begin
          state_d = ST_PUSH_PC;
          kind_d = KIND_TRAP;
          // (RULE15) trap field picks vector
          vec_num_d = VEC_TRAP0 + VEC_W'(trap_pend_q ? trap_num_q : trap_num);
        end
      end
      // (RULE5) pc first, then ccr
      ST_PUSH_PC:
        if (stack_ack)
          state_d = ST_PUSH_CCR;
      ST_PUSH_CCR:
        if (stack_ack)
          state_d = ST_SET_MASK;
      ST_SET_MASK:
        state_d = ST_FETCH;
      ST_FETCH:
        if (vec_ack)
          state_d = ST_JUMP;
      default:
        state_d = ST_RESET;
    endcase
  end

  // (RULE11) (RULE13) reset pin or watchdog holds reset state
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      state_q <= ST_RESET;
      kind_q <= KIND_RESET;
      vec_num_q <= 6'h00;
    end
    else if (wdt_overflow)
    begin
      state_q <= ST_RESET;
      kind_q <= KIND_RESET;
      vec_num_q <= VEC_RESET;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      vec_num_q <= vec_num_d;
    end
  end

  // (RULE18) strap caught while in reset state
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      adv_q <= 1'b0;
    else if (state_q == ST_RESET)
      adv_q <= advanced_mode_cfg;
  end

  // ==========================================================
  // trap held while an interrupt goes first
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      trap_pend_q <= 1'b0;
      trap_num_q <= 2'h0;
    end
    else if (wdt_overflow)
      trap_pend_q <= 1'b0;
    // (RULE1) queued trap served after interrupt
    else if (trap_instr && (state_d != ST_PUSH_PC || kind_d != KIND_TRAP))
    begin
      trap_pend_q <= 1'b1;
      trap_num_q <= trap_num;
    end
    else if (state_d == ST_PUSH_PC && kind_d == KIND_TRAP)
      trap_pend_q <= 1'b0;
  end

  // ==========================================================
  // post-reset block
  // no stack pointer yet, so stacking would corrupt memory
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      block_q <= 1'b1;
    // (RULE16) armed by reset, freed by first instruction
    else if (wdt_overflow || state_q == ST_RESET)
      block_q <= 1'b1;
    else if (state_q == ST_RUN && instr_done)
      block_q <= 1'b0;
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      cpu_halt <= 1'b1;
      periph_reset_n <= 1'b0;
      stack_push <= 1'b0;
      stack_data <= 24'h000000;
      vec_read <= 1'b0;
      ccr_set_i <= 1'b0;
      ccr_set_ui <= 1'b0;
      exec_start <= 1'b0;
      exec_pc <= 24'h000000;
      int_ack <= 1'b0;
      int_blocked <= 1'b1;
    end
    else
    begin
      // (RULE12) peripherals held in reset with the cpu
      cpu_halt <= wdt_overflow || (state_d == ST_RESET);
      periph_reset_n <= !(wdt_overflow || (state_d == ST_RESET));
      stack_push <= !wdt_overflow && (state_d == ST_PUSH_PC || state_d == ST_PUSH_CCR);
      if (state_d == ST_PUSH_CCR)
        stack_data <= PC_W'(cond_code_reg);
      else if (state_d == ST_PUSH_PC)
        stack_data <= pc_in;
      vec_read <= !wdt_overflow && (state_d == ST_FETCH);
      // (RULE5) mask bit set after stacking
      ccr_set_i <= !wdt_overflow && (state_d == ST_SET_MASK);
      // (RULE14) user mask too on a trap when enable is clear
      ccr_set_ui <= !wdt_overflow && (state_d == ST_SET_MASK) &&
                    (kind_d == KIND_TRAP) && !user_bit_enable;
      exec_start <= !wdt_overflow && (state_d == ST_JUMP);
      if (state_q == ST_FETCH && vec_ack)
        exec_pc <= vec_data;
      // only an acceptance from run or jump counts, never a stray boundary mid-sequence
      int_ack <= !wdt_overflow && take_int && (state_d == ST_PUSH_PC) &&
                 (state_q == ST_RUN || state_q == ST_JUMP);
      int_blocked <= block_q;
    end
  end

endmodule : exception_priority_vectoring
`default_nettype wire

/* exc_pkg.sv */
// constants, state codes and vector numbers of the exception sequencer
//
// Overview of operation
// (RULE1) rank reset, then interrupt, then trap
// (RULE2) take trap whenever program executes
// (RULE3) reset sequence starts at reset release
// (RULE4) interrupt waits for instruction or sequence end
// (RULE5) stack pc, ccr; set mask; vector
// (RULE6) reset skips stacking; mask, vector, run
// (RULE7) own vector per source; reset vector zero
// (RULE8) vectors 0 to 63; 4/2 byte entries
// (RULE9) nmi 7, traps 8-11, irq 12-17
// (RULE10) vectors 1-6, 18, 19 reserved
// (RULE11) reset low halts all processing
// (RULE12) reset initialises cpu and peripherals
// (RULE13) watchdog overflow resets like reset pin
// (RULE14) trap sets user mask when enable clear
// (RULE15) trap field picks trap vector 0-3
// (RULE16) block interrupts until first instruction runs
// (RULE17) running reset held low ten cycles
// (RULE18) entry size from strap caught at reset
package exc_pkg;

  // ==========================================================
  // widths
  localparam int VEC_W = 6;
  localparam int ADDR_W = 16;
  localparam int CCR_W = 8;
  localparam int PC_W = 24;

  // ==========================================================
  // vector numbers
  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic [5:0] VEC_SYS_LO = 6'h01;
  localparam logic [5:0] VEC_SYS_HI = 6'h06;
  localparam logic [5:0] VEC_NMI = 6'h07;
  localparam logic [5:0] VEC_TRAP0 = 6'h08;
  localparam logic [5:0] VEC_IRQ0 = 6'h0C;
  localparam logic [5:0] VEC_IRQ5 = 6'h11;
  localparam logic [5:0] VEC_RSV18 = 6'h12;
  localparam logic [5:0] VEC_RSV19 = 6'h13;
  localparam logic [5:0] VEC_INT_LO = 6'h14;
  localparam logic [5:0] VEC_LAST = 6'h3F;

  // ==========================================================
  // vector table entry shift: 4-byte advanced, 2-byte normal
  localparam int SHIFT_ADV = 2;
  localparam int SHIFT_NRM = 1;

  // ==========================================================
  // timing expected from the reset source
  localparam int CLK_NS = 100;
  localparam int RST_HOLD_CYC = 10;

  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_RESET = 7'h01,
    ST_RUN = 7'h02,
    ST_PUSH_PC = 7'h04,
    ST_PUSH_CCR = 7'h08,
    ST_SET_MASK = 7'h10,
    ST_FETCH = 7'h20,
    ST_JUMP = 7'h40
  } state_t;

  typedef enum logic [1:0] {
    KIND_RESET = 2'h0,
    KIND_INT = 2'h1,
    KIND_TRAP = 2'h2
  } kind_t;

  // reserved for system use
  function automatic logic vec_reserved(input logic [5:0] v);
    vec_reserved = ((v >= VEC_SYS_LO) && (v <= VEC_SYS_HI)) ||
                   (v == VEC_RSV18) || (v == VEC_RSV19);
  endfunction : vec_reserved

endpackage : exc_pkg

/* vec_addr_gen.sv */
// vector number to vector table address, registered
`timescale 1ns/10ps
`default_nettype none
module vec_addr_gen
  import exc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [VEC_W-1:0] vec_num,
  input wire logic advanced,
  output logic [ADDR_W-1:0] addr_q
);

  logic [ADDR_W-1:0] addr_d;

  // ==========================================================
  // address forming
  always_comb
  begin
    // (RULE8) entry size by mode
    if (advanced)
      addr_d = ADDR_W'({10'h000, vec_num} << SHIFT_ADV);
    else
      addr_d = ADDR_W'({10'h000, vec_num} << SHIFT_NRM);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      addr_q <= 16'h0000;
    else
      addr_q <= addr_d;
  end

endmodule : vec_addr_gen
`default_nettype wire

/* epv_properties.sv */
// concurrent checks on the exception sequencer ports
`timescale 1ns/10ps
`default_nettype none
module epv_checker
  import exc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic user_bit_enable,
  input wire logic int_req,
  input wire logic [VEC_W-1:0] int_vec,
  input wire logic stack_ack,
  input wire logic vec_ack,
  input wire logic [PC_W-1:0] vec_data,
  input wire logic cpu_halt,
  input wire logic periph_reset_n,
  input wire logic stack_push,
  input wire logic [PC_W-1:0] stack_data,
  input wire logic vec_read,
  input wire logic [ADDR_W-1:0] vec_addr,
  input wire logic ccr_set_i,
  input wire logic ccr_set_ui,
  input wire logic exec_start,
  input wire logic [PC_W-1:0] exec_pc,
  input wire logic int_ack,
  input wire logic int_blocked
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // outputs settle on the reset flops, so they are judged one edge after the pin is seen low
  property p_halt; disable iff (1'b0) !reset_n |=> cpu_halt && !periph_reset_n; endproperty
  a_halt: assert property (p_halt) else $error("core not halted in reset");
  property p_rel; $fell(cpu_halt) |-> ccr_set_i && periph_reset_n && int_blocked; endproperty
  a_rel: assert property (p_rel) else $error("bad reset release");
  property p_rvec; $fell(cpu_halt) |=> vec_read && vec_addr == 16'h0000; endproperty
  a_rvec: assert property (p_rvec) else $error("reset vector not fetched");
  property p_vec; vec_read && vec_ack |=> exec_start && exec_pc == $past(vec_data); endproperty
  a_vec: assert property (p_vec) else $error("no start after fetch");
  property p_hold; stack_push && !stack_ack |=> stack_push && $stable(stack_data); endproperty
  a_hold: assert property (p_hold) else $error("push word dropped");
  property p_range; vec_read |-> vec_addr <= 16'h00FF && !vec_addr[0]; endproperty
  a_range: assert property (p_range) else $error("vector address out of table");
  property p_ui; ccr_set_ui |-> ccr_set_i && !user_bit_enable; endproperty
  a_ui: assert property (p_ui) else $error("user mask set wrongly");
  property p_mask; $fell(stack_push) |-> ccr_set_i; endproperty
  a_mask: assert property (p_mask) else $error("mask not set after stacking");
  property p_iack; int_ack |-> $past(int_req) && !$past(int_blocked) && stack_push &&
    $past(int_vec) > 6'h06 && $past(int_vec) != 6'h12 && $past(int_vec) != 6'h13; endproperty
  a_iack: assert property (p_iack) else $error("bad interrupt accept");
endmodule : epv_checker

bind exception_priority_vectoring epv_checker chk (.clk, .reset_n, .user_bit_enable,
  .int_req, .int_vec, .stack_ack, .vec_ack, .vec_data, .cpu_halt, .periph_reset_n,
  .stack_push, .stack_data, .vec_read, .vec_addr, .ccr_set_i, .ccr_set_ui, .exec_start,
  .exec_pc, .int_ack, .int_blocked);
`default_nettype wire

/* cpu_side_model.sv */
// far-side model: stack memory and vector table reads
`timescale 1ns/10ps
`default_nettype none
module cpu_side_model (
  input wire logic clk,
  input wire logic [3:0] dly,
  input wire logic stack_push,
  input wire logic vec_read,
  input wire logic [15:0] vec_addr,
  output logic stack_ack,
  output logic vec_ack,
  output logic [23:0] vec_data
);
  logic [3:0] sc_q, vc_q;
  initial
  begin
    {sc_q, vc_q, stack_ack, vec_ack} = '0;
    vec_data = 24'h000000;
  end
  // ==========================================================
  // acks after dly wait cycles; data scrambled outside the ack cycle
  always @(posedge clk)
  begin
    sc_q <= (stack_push && !stack_ack) ? sc_q + 4'h1 : 4'h0;
    stack_ack <= stack_push && !stack_ack && sc_q >= dly;
    vc_q <= (vec_read && !vec_ack) ? vc_q + 4'h1 : 4'h0;
    vec_ack <= vec_read && !vec_ack && vc_q >= dly;
    vec_data <= (vec_read && !vec_ack && vc_q >= dly) ? {8'h5A, vec_addr} : ~vec_data;
  end
endmodule : cpu_side_model
`default_nettype wire

/* test_exception_priority_vectoring.sv */
// self-checking bench for the exception sequencer
`timescale 1ns/10ps
`default_nettype none
module test_exception_priority_vectoring;
  import exc_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, wdt_overflow = 1'b0, advanced_mode_cfg = 1'b1;
  logic user_bit_enable = 1'b1, instr_done = 1'b0, int_req = 1'b0, trap_instr = 1'b0;
  logic [5:0] int_vec = 6'h07;
  logic [1:0] trap_num = 2'h0;
  logic [23:0] pc_in = 24'h12345A;
  logic [7:0] cond_code_reg = 8'h85;
  logic [3:0] dly = 4'h0;
  logic stack_ack, vec_ack, cpu_halt, periph_reset_n, stack_push, vec_read, ccr_set_i;
  logic ccr_set_ui, exec_start, int_ack, int_blocked;
  logic [23:0] vec_data, stack_data, exec_pc;
  logic [15:0] vec_addr, vaddr;
  logic [23:0] pushed[$];
  int acks = 0, ui_n = 0, errors = 0, samples_checked = 0;

  always #50 clk = ~clk;

  exception_priority_vectoring dut (.clk, .reset_n, .wdt_overflow, .advanced_mode_cfg,
    .user_bit_enable, .instr_done, .int_req, .int_vec, .trap_instr, .trap_num, .pc_in,
    .cond_code_reg, .stack_ack, .vec_ack, .vec_data, .cpu_halt, .periph_reset_n,
    .stack_push, .stack_data, .vec_read, .vec_addr, .ccr_set_i, .ccr_set_ui, .exec_start,
    .exec_pc, .int_ack, .int_blocked);
  cpu_side_model far (.clk, .dly, .stack_push, .vec_read, .vec_addr, .stack_ack, .vec_ack,
    .vec_data);

  // ==========================================================
  // monitor; the interrupt source drops its request once accepted
  always @(posedge clk)
  begin
    if (stack_push && stack_ack)
      pushed.push_back(stack_data);
    if (vec_read && vec_ack)
      vaddr = vec_addr;
    if (ccr_set_ui)
      ui_n++;
    if (int_ack)
    begin
      acks++;
      int_req <= 1'b0;
    end
  end

  function automatic logic [15:0] va(input logic [5:0] v);
    va = advanced_mode_cfg ? {8'h00, v, 2'b00} : {9'h000, v, 1'b0};
  endfunction : va

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic pulse(input logic t, input logic r);
    @(posedge clk);
    instr_done <= 1'b1;
    trap_instr <= t;
    if (r)
      int_req <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
    trap_instr <= 1'b0;
  endtask : pulse

  // waits for a start, then judges its vector address, start address, pushed words and user mask sets
  task automatic expect_exc(input logic [5:0] v, input int np, input int ui);
    int i = 0;
    do
    begin
      @(posedge clk);
      #1;
      i++;
    end
    while (exec_start !== 1'b1 && i < 400);
    if (exec_start !== 1'b1)
    begin
      errors++;
      final_report();
    end
    check("vector address", {8'h00, vaddr}, {8'h00, va(v)});
    check("start address", exec_pc, {8'h5A, va(v)});
    check("words pushed", 24'(pushed.size()), 24'(np));
    if (np == 2)
    begin
      check("pushed pc", pushed[0], pc_in);
      check("pushed ccr", pushed[1], {16'h0000, cond_code_reg});
    end
    check("user mask sets", 24'(ui_n), 24'(ui));
    pushed.delete();
    ui_n = 0;
  endtask : expect_exc

  // ==========================================================
  // scenarios
  task automatic scn_power_up;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    expect_exc(VEC_RESET, 0, 0);
    check("blocked", {23'h0, int_blocked}, 24'h000001);
  endtask : scn_power_up

  task automatic scn_blocked_then_nmi;
    pulse(1'b0, 1'b1);
    repeat (4) @(posedge clk);
    check("ack while blocked", 24'(acks), 24'h0);
    pulse(1'b0, 1'b0);
    expect_exc(VEC_NMI, 2, 0);
  endtask : scn_blocked_then_nmi

  task automatic scn_traps;
    for (int n = 0; n < 4; n++)
    begin
      @(posedge clk);
      user_bit_enable <= n[0];
      trap_num <= 2'(n);
      dly <= 4'(n);
      pulse(1'b1, 1'b0);
      expect_exc(6'(8 + n), 2, n[0] ? 0 : 1);
    end
  endtask : scn_traps

  task automatic scn_int_over_trap;
    @(posedge clk);
    int_vec <= 6'h14;
    pulse(1'b1, 1'b1);
    expect_exc(6'h14, 2, 0);
    expect_exc(6'h0B, 2, 0);
  endtask : scn_int_over_trap

  // refused codes must leave no trace
  task automatic scn_reserved;
    for (int v = 1; v < 20; v = (v == 6) ? 18 : v + 1)
    begin
      @(posedge clk);
      int_vec <= 6'(v);
      pulse(1'b0, 1'b1);
      repeat (4) @(posedge clk);
      check("reserved ack", 24'(acks) + 24'(pushed.size()), 24'h2);
    end
  endtask : scn_reserved

  task automatic scn_watchdog;
    @(posedge clk);
    int_req <= 1'b0;
    wdt_overflow <= 1'b1;
    @(posedge clk);
    wdt_overflow <= 1'b0;
    expect_exc(VEC_RESET, 0, 0);
  endtask : scn_watchdog

  task automatic scn_run_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    advanced_mode_cfg <= 1'b0;
    repeat (RST_HOLD_CYC) @(posedge clk);
    check("halt state", {22'h0, cpu_halt, periph_reset_n}, 24'h000002);
    reset_n <= 1'b1;
    expect_exc(VEC_RESET, 0, 0);
  endtask : scn_run_reset

  task automatic scn_last_vector;
    pulse(1'b0, 1'b0);
    @(posedge clk);
    int_vec <= VEC_LAST;
    pulse(1'b0, 1'b1);
    expect_exc(VEC_LAST, 2, 0);
  endtask : scn_last_vector

  initial
  begin
    scn_power_up();
    scn_blocked_then_nmi();
    scn_traps();
    scn_int_over_trap();
    scn_reserved();
    scn_watchdog();
    scn_run_reset();
    scn_last_vector();
    final_report();
  end
endmodule : test_exception_priority_vectoring
`default_nettype wire
